// ### tb/pccard_card_model.sv
// Purpose: Card side request pins for the DMA selection tests.
// Assumes: Pins idle high, as their pull-ups would hold them.
// Notes:   Only the pin named by pin_sel carries a request.
module pccard_card_model (
	input  wire logic [1:0] pin_sel,
	input  wire logic       req_on,
	output logic            inpack_n,
	output logic            wp_iois16_n,
	output logic            bvd2_spkr_n
);
	// Active-low request on at most one pin; codes follow the select field, code 0 names none.
	assign inpack_n = !(req_on && pin_sel == 2'h1);
	assign wp_iois16_n = !(req_on && pin_sel == 2'h2);
	assign bvd2_spkr_n = !(req_on && pin_sel == 2'h3);
endmodule

// ### tb/pccard_ext_chk.sv
// Purpose: Port assertions for the extended control block.
// Assumes: One clock; rst_b resets; four core cycles per tick.
// Notes:   Dummy length figures fixed for DUMMY_CLKS of 2.
module pccard_ext_chk #(
	parameter int DUMMY_CLKS = 2
) (
	input wire logic                      core_clk,
	input wire logic                      rst_b,
	input wire pccard_ext_pkg::reg_req_t  reg_req,
	input wire logic [7:0]                reg_rdata,
	input wire logic [7:0]                data_drive_en,
	input wire logic                      force_8bit,
	input wire logic                      cd_pullup_en,
	input wire logic                      socket_a_gp_strobe_pullup_en,
	input wire logic                      card_cycle_active,
	input wire logic                      activity_led_n,
	input wire logic                      dma_mode,
	input wire logic                      card_dreq,
	input wire logic                      dack_n,
	input wire logic                      iow_n,
	input wire logic                      tc,
	input wire pccard_ext_pkg::card_dma_t card_dma
);
	import pccard_ext_pkg::*;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// The earliest timeout is 24 cycles, so 23 quiet cycles follow a fall.
	sequence quiet8;
		!card_dma.dummy_rd [*8];
	endsequence
	sequence burst;
		card_dma.dummy_rd [*8] ##1 !card_dma.dummy_rd;
	endsequence
	a_pullup_same: assert property (cd_pullup_en == socket_a_gp_strobe_pullup_en)
		else $error("pull-up enables differ");
	a_mask_force: assert property ($past(rst_b) |->
		force_8bit == (data_drive_en != 8'hFF)) else $error("force mismatch");
	a_led_idle: assert property ($past(rst_b) && !$past(card_cycle_active)
		|-> activity_led_n) else $error("led lit while idle");
	a_dreq_off: assert property (!dma_mode |-> !card_dreq)
		else $error("request outside dma mode");
	a_dummy_cause: assert property ($rose(card_dma.dummy_rd) |->
		!$past(dack_n) && $past(iow_n) && $past(dma_mode))
		else $error("dummy without cause");
	a_dummy_len: assert property ($rose(card_dma.dummy_rd) |-> burst)
		else $error("dummy length wrong");
	// The terminal count seen by the card is registered one cycle late.
	a_dummy_ack: assert property (card_dma.dummy_rd |->
		card_dma.dack && card_dma.tc == $past(tc)) else $error("dummy ack wrong");
	a_min_delay: assert property ($fell(dack_n) |->
		quiet8 ##1 quiet8 ##1 !card_dma.dummy_rd [*7])
		else $error("dummy too early");
	a_rdata_hold: assert property ($past(rst_b) && !$past(reg_req.rd)
		|-> $stable(reg_rdata)) else $error("read data moved");
endmodule

// ### tb/tb_pccard_ext_ctrl_dma_ack_timeout.sv
// Purpose: Self-checking bench for the extended control block.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes:   Reset checks and register rows first, then hand-written cases.
`include "pccard_ext_map.svh"
module tb_pccard_ext_ctrl_dma_ack_timeout;
	timeunit 1ns;
	timeprecision 1ns;
	import pccard_ext_pkg::*;
	typedef struct packed { logic [7:0] i, d, e; } row_t;
	logic core_clk = 0, rst_b = 0, clk_en = 1, host_io_access = 0;
	logic win0_hit = 0, win1_hit = 0, card_detect_raw = 1, tc = 0;
	logic card_cycle_active = 0, dack_n = 1, ior_n = 1, iow_n = 1, req_on = 0;
	logic [1:0] pin_sel = 2'h0;
	logic [7:0] reg_rdata, data_drive_en, rd_val;
	logic force_8bit, card_power_en, cd_pullup_en, activity_led_n;
	logic socket_a_gp_strobe_pullup_en, socket_b_gp_strobe_pullup_en;
	logic inpack_n, wp_iois16_n, bvd2_spkr_n, dma_mode, card_dreq;
	reg_req_t reg_req = '0;
	card_dma_t card_dma;
	int miscompares = 0, checked = 0, cyc = 0, n;
	row_t rows[5] = '{'{8'h01, 8'hA5, 8'hA5}, '{8'h02, 8'h5A, 8'h5A},
		'{8'h03, 8'hFF, 8'hE7}, '{8'h04, 8'hB0, 8'hB0}, '{8'h07, 8'hFF, 8'h00}};
	logic [7:0] dly[4] = '{8'h80, 8'h20, 8'hB0, 8'h00};
	int clks[4] = '{7, 10, 19, 6};
	pccard_ext_ctrl_dma_ack_timeout i_dut (.core_clk, .rst_b, .clk_en,
		.reg_req, .reg_rdata, .host_io_access, .win0_hit, .win1_hit,
		.data_drive_en, .force_8bit, .card_power_en, .card_detect_raw,
		.cd_pullup_en, .socket_a_gp_strobe_pullup_en,
		.socket_b_gp_strobe_pullup_en, .card_cycle_active, .activity_led_n,
		.inpack_n, .wp_iois16_n, .bvd2_spkr_n, .dma_mode, .card_dreq,
		.dack_n, .ior_n, .iow_n, .tc, .card_dma);
	pccard_card_model i_card (.pin_sel, .req_on, .inpack_n, .wp_iois16_n,
		.bvd2_spkr_n);
	initial forever #5 core_clk = ~core_clk;
	// A hang of any wait ends the run as a mismatch.
	always @(posedge core_clk) begin
		if (++cyc == 20000) begin
			miscompares++;
			give_verdict;
		end
	end
	task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	// One request cycle; read data is taken one cycle after rd.
	task automatic bus(logic w, logic r, logic [7:0] i, logic [7:0] d);
		@(posedge core_clk) #1;
		reg_req = '{w, r, i, d};
		@(posedge core_clk) #1;
		reg_req = '0;
		rd_val = reg_rdata;
	endtask
	task automatic xw(logic [7:0] i, logic [7:0] d);
		bus(1, 0, `EXT_INDEX_REG, i);
		bus(1, 0, `EXT_DATA_REG, d);
	endtask
	task automatic xr(logic [7:0] i);
		bus(1, 0, `EXT_INDEX_REG, i);
		bus(0, 1, `EXT_DATA_REG, 8'h00);
	endtask
	task automatic tick(int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask
	task automatic give_verdict;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		tick(8);
		rst_b = 1;
		tick(1);
		check("drive", data_drive_en, 8'hFF);
		for (n = 1; n < 5; n++) begin
			xr(n[7:0]);
			check("rst", rd_val, 8'h00);
		end
		foreach (rows[k]) begin
			xw(rows[k].i, rows[k].d);
			xr(rows[k].i);
			check("reg", rd_val, rows[k].e);
		end
		xw(`XIDX_CTRL1, 8'h00);
		xw(`XIDX_MASK0, 8'h7F);
		xw(`XIDX_MASK1, 8'h00);
		host_io_access = 1;
		win0_hit = 1;
		tick(2);
		check("win0", data_drive_en, 8'h80);
		check("f0", 8'(force_8bit), 8'h01);
		win0_hit = 0;
		win1_hit = 1;
		tick(2);
		check("win1", data_drive_en, 8'hFF);
		xw(`XIDX_MASK1, 8'h0F);
		tick(2);
		check("win1m", data_drive_en, 8'hF0);
		host_io_access = 0;
		xw(`XIDX_CTRL1, 8'h04);
		card_cycle_active = 1;
		tick(2);
		check("led", 8'(activity_led_n), 8'h00);
		bus(1, 0, `PWR_CTRL_REG, 8'h10);
		xw(`XIDX_CTRL1, 8'h01);
		bus(1, 0, `PWR_CTRL_REG, 8'h00);
		tick(2);
		check("lock", 8'(card_power_en), 8'h01);
		xw(`XIDX_CTRL1, 8'h22);
		card_detect_raw = 0;
		tick(3);
		check("pu", 8'(cd_pullup_en), 8'h00);
		check("pub", 8'(socket_b_gp_strobe_pullup_en), 8'h00);
		check("keep", 8'(card_power_en), 8'h01);
		xw(`XIDX_CTRL1, 8'h00);
		card_detect_raw = 1;
		tick(3);
		card_detect_raw = 0;
		tick(3);
		check("clr", 8'(card_power_en), 8'h00);
		for (n = 1; n < 4; n++) begin
			xw(`XIDX_CTRL1, {n[1:0], 6'h00});
			pin_sel = n[1:0];
			req_on = 1;
			tick(2);
			check("dreq", 8'({dma_mode, card_dreq}), 8'h03);
			pin_sel = 2'(n % 3 + 1);
			tick(2);
			check("other", 8'(card_dreq), 8'h00);
			req_on = 0;
		end
		tc = 1;
		// First two delays are the recommended values for hosts and cards.
		foreach (dly[k]) begin
			xw(`XIDX_ACK_DELAY, dly[k]);
			dack_n = 0;
			n = 0;
			while (card_dma.dummy_rd !== 1'b1 && n < 200) begin
				tick(1);
				n++;
			end
			check("dly", 8'(n >= clks[k] * 4 && n <= clks[k] * 4 + 3), 8'h01);
			check("tc", 8'(card_dma.tc), 8'h01);
			tick(12);
			dack_n = 1;
			tick(2);
		end
		dack_n = 0;
		tick(5);
		iow_n = 0;
		n = 0;
		repeat (100) begin
			tick(1);
			if (card_dma.dummy_rd === 1'b1) n++;
		end
		check("cancel", 8'(n), 8'h00);
		give_verdict;
	end
endmodule
bind pccard_ext_ctrl_dma_ack_timeout pccard_ext_chk #(
	.DUMMY_CLKS(DUMMY_CLKS)
) i_chk (.core_clk, .rst_b, .reg_req, .reg_rdata, .data_drive_en,
	.force_8bit, .cd_pullup_en, .socket_a_gp_strobe_pullup_en,
	.card_cycle_active, .activity_led_n, .dma_mode, .card_dreq, .dack_n,
	.iow_n, .tc, .card_dma);

// ### verilog/pccard_ext_ctrl_dma_ack_timeout.sv
// Purpose: Per-socket extended control registers: I/O window data masks,
//          power lock and auto clear, activity LED, pull-up control, DMA
//          request pin selection and the DMA acknowledge timeout.
// Assumes: All inputs synchronous to core_clk; one socket per instance.
// Notes:   The 25 MHz internal clock is a prescaled tick of core_clk.
//
// How it works
// - Bits set in the window 0 mask are not driven on host I/O to window 0.
// - A zero mask, the reset value, drives every data bit for that window.
// - Any set mask bit forces accesses to that window to 8-bit operation.
// - The window 1 mask acts the same way on window 1 accesses.
// - With power lock set, software writes to the supply enable bit drop.
// - Card removal clears the supply enable unless auto clear is disabled.
// - With the activity enable set, the LED output is low during cycles.
// - The pull-up control bit turns off card-detect and strobe pull-ups.
// - With pull-ups off the card-detect input is ignored too.
// - The DMA enable field resets to zero; any nonzero code is DMA mode.
// - Codes 01, 10, 11 pick the input-ack, write-protect or speaker pin.
// - A timeout after acknowledge with no read or write runs a dummy cycle.
// - The dummy cycle passes acknowledge and terminal count to the card.
// - The delay is a count of internal clocks, 80h giving seven.
// - Extended registers are reached through an index and a data register.
`include "pccard_ext_map.svh"

module pccard_ext_ctrl_dma_ack_timeout #(
	parameter int DUMMY_CLKS = `DUMMY_CLKS
) (
	input  wire logic                     core_clk,
	input  wire logic                     rst_b,
	input  wire logic                     clk_en,
	input  wire pccard_ext_pkg::reg_req_t reg_req,
	output logic [7:0]                    reg_rdata,
	input  wire logic                     host_io_access,
	input  wire logic                     win0_hit,
	input  wire logic                     win1_hit,
	output logic [7:0]                    data_drive_en,
	output logic                          force_8bit,
	output logic                          card_power_en,
	input  wire logic                     card_detect_raw,
	output logic                          cd_pullup_en,
	output logic                          socket_a_gp_strobe_pullup_en,
	output logic                          socket_b_gp_strobe_pullup_en,
	input  wire logic                     card_cycle_active,
	output logic                          activity_led_n,
	input  wire logic                     inpack_n,
	input  wire logic                     wp_iois16_n,
	input  wire logic                     bvd2_spkr_n,
	output logic                          dma_mode,
	output logic                          card_dreq,
	input  wire logic                     dack_n,
	input  wire logic                     ior_n,
	input  wire logic                     iow_n,
	input  wire logic                     tc,
	output pccard_ext_pkg::card_dma_t     card_dma
);
	import pccard_ext_pkg::*;

	// Core cycles per internal clock, derived from the two periods.
	localparam int TICK_CYC = `INT_CLK_NS / `CORE_CLK_NS;
	localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);
	localparam logic [7:0] DUMMY_LAST = 8'(DUMMY_CLKS * TICK_CYC - 1);

	// Refuse timings the counters cannot hold.
	if (TICK_CYC < 1 || TICK_CYC > 256) begin : g_bad_tick
		$error("internal clock period does not fit the prescaler");
	end
	if (DUMMY_CLKS < 1 || DUMMY_CLKS * TICK_CYC > 256) begin : g_bad_dummy
		$error("DUMMY_CLKS out of range");
	end

	state_t st;
	state_t next_st;
	logic [7:0] ack_rev;
	logic [8:0] ack_limit;
	logic       cd_seen;
	logic       acked;
	logic       cmd_seen;
	logic       tick;
	logic       vcc_next;

	// Bit-reverse the delay register with one generate loop.
	for (genvar i = 0; i < 8; i++) begin : g_rev
		assign ack_rev[i] = st.ack_delay[7 - i];
	end

	// Timeout in internal clocks; zero reset value gives the base six.
	assign ack_limit = `ACK_BASE_CLKS + {1'b0, ack_rev};

	// Card detect is ignored while its pull-up is off.
	assign cd_seen = st.pullups_on ? card_detect_raw : st.cd_prev;
	assign acked = !dack_n && st.dack_prev;
	assign cmd_seen = !ior_n || !iow_n;
	assign tick = (st.prescale == TICK_LAST);

	// Next state of the whole block.
	always_comb begin
		next_st = st;
		vcc_next = st.pwr_ctrl[`PWR_VCC_BIT];

		// Index/data register port.
		if (reg_req.wr) begin
			unique case (reg_req.index)
				`EXT_INDEX_REG: begin
					next_st.ext_index = reg_req.wdata;
				end
				`EXT_DATA_REG: begin
					unique case (st.ext_index)
						`XIDX_MASK0: begin
							next_st.mask0 = reg_req.wdata;
						end
						`XIDX_MASK1: begin
							next_st.mask1 = reg_req.wdata;
						end
						`XIDX_CTRL1: begin
							next_st.ctrl1 = reg_req.wdata & `CTRL1_WMASK;
						end
						`XIDX_ACK_DELAY: begin
							next_st.ack_delay = reg_req.wdata;
						end
						default: begin
						end
					endcase
				end
				`PWR_CTRL_REG: begin
					next_st.pwr_ctrl = reg_req.wdata;
					// Locked supply bit keeps its value.
					if (st.ctrl1[`CTRL1_LOCK_BIT]) begin
						next_st.pwr_ctrl[`PWR_VCC_BIT] = vcc_next;
					end
				end
				default: begin
				end
			endcase
		end

		// Removal beats a write in the same cycle, so power drops safely.
		if (st.cd_prev && !cd_seen && !st.ctrl1[`CTRL1_AUTOCLR_BIT]) begin
			next_st.pwr_ctrl[`PWR_VCC_BIT] = 1'b0;
		end
		next_st.cd_prev = cd_seen;

		// Read data is captured when the read strobe is seen.
		if (reg_req.rd) begin
			next_st.rdata = 8'h00;
			unique case (reg_req.index)
				`EXT_INDEX_REG: begin
					next_st.rdata = st.ext_index;
				end
				`EXT_DATA_REG: begin
					unique case (st.ext_index)
						`XIDX_MASK0: begin
							next_st.rdata = st.mask0;
						end
						`XIDX_MASK1: begin
							next_st.rdata = st.mask1;
						end
						`XIDX_CTRL1: begin
							next_st.rdata = st.ctrl1;
						end
						`XIDX_ACK_DELAY: begin
							next_st.rdata = st.ack_delay;
						end
						default: begin
						end
					endcase
				end
				`PWR_CTRL_REG: begin
					next_st.rdata = st.pwr_ctrl;
				end
				default: begin
				end
			endcase
		end

		// Data bit drive enables and bus width for the decoded window.
		next_st.data_drive_en = 8'hFF;
		next_st.force_8bit = 1'b0;
		if (host_io_access && win0_hit) begin
			next_st.data_drive_en = ~st.mask0;
			next_st.force_8bit = |st.mask0;
		end else if (host_io_access && win1_hit) begin
			next_st.data_drive_en = ~st.mask1;
			next_st.force_8bit = |st.mask1;
		end

		// Activity LED, active low.
		next_st.activity_led_n =
			!(st.ctrl1[`CTRL1_LED_BIT] && card_cycle_active);

		// Pull-ups are on while the control bit is clear.
		next_st.pullups_on = !st.ctrl1[`CTRL1_PULLUP_BIT];

		// DMA mode and request pin selection.
		next_st.dma_mode =
			(st.ctrl1[`CTRL1_DMA_HI:`CTRL1_DMA_LO] != `DMA_OFF);
		unique case (st.ctrl1[`CTRL1_DMA_HI:`CTRL1_DMA_LO])
			`DMA_SEL_INPACK: next_st.card_dreq = !inpack_n;
			`DMA_SEL_WP:     next_st.card_dreq = !wp_iois16_n;
			`DMA_SEL_BVD2:   next_st.card_dreq = !bvd2_spkr_n;
			default:         next_st.card_dreq = 1'b0;
		endcase

		// Acknowledge timeout sequencer; the prescaler always runs.
		next_st.dack_prev = dack_n;
		next_st.prescale = tick ? 8'h00 : st.prescale + 8'h01;
		next_st.card_dma = '0;
		unique case (st.dma_state)
			DMA_IDLE: begin
				if (st.dma_mode && acked) begin
					next_st.dma_state = DMA_TIMING;
					next_st.prescale = 8'h00;
					next_st.ticks = 9'h000;
				end
			end
			DMA_TIMING: begin
				if (dack_n || cmd_seen) begin
					// Host ran its own cycle or withdrew the acknowledge.
					next_st.dma_state = DMA_WAIT_RELEASE;
				end else if (tick) begin
					next_st.ticks = st.ticks + 9'h001;
					if (st.ticks + 9'h001 == ack_limit) begin
						next_st.dma_state = DMA_DUMMY;
						next_st.dummy_cnt = 8'h00;
					end
				end
			end
			DMA_DUMMY: begin
				// Dummy write at the host is a read strobe at the card.
				next_st.card_dma.dummy_rd = 1'b1;
				next_st.card_dma.dack = 1'b1;
				next_st.card_dma.tc = tc;
				next_st.dummy_cnt = st.dummy_cnt + 8'h01;
				// The last count still drives, so the cycle stands a full
				// DUMMY_CLKS internal clocks before the release state.
				if (st.dummy_cnt == DUMMY_LAST) begin
					next_st.dma_state = DMA_WAIT_RELEASE;
				end
			end
			DMA_WAIT_RELEASE: begin
				// One dummy per acknowledge; re-arm only once it drops.
				if (dack_n) begin
					next_st.dma_state = DMA_IDLE;
				end
			end
		endcase
	end

	// State register; clk_en freezes everything.
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
			st.ext_index <= `EXT_INDEX_RST;
		end else if (clk_en) begin
			st <= next_st;
		end
	end

	// Outputs straight from the state flops.
	assign reg_rdata = st.rdata;
	assign data_drive_en = st.data_drive_en;
	assign force_8bit = st.force_8bit;
	assign card_power_en = st.pwr_ctrl[`PWR_VCC_BIT];
	assign cd_pullup_en = st.pullups_on;
	assign socket_a_gp_strobe_pullup_en = st.pullups_on;
	assign socket_b_gp_strobe_pullup_en = st.pullups_on;
	assign activity_led_n = st.activity_led_n;
	assign dma_mode = st.dma_mode;
	assign card_dreq = st.card_dreq;
	assign card_dma = st.card_dma;

endmodule

// ### verilog/pccard_ext_map.svh
// Purpose: Offsets, field positions, reset values and timing counts for the
//          per-socket extended control block.
// Assumes: Included by its bare name; definitions only.
// Notes:   Outer indices select registers in the controller's index space.
`ifndef PCCARD_EXT_MAP_SVH
`define PCCARD_EXT_MAP_SVH

// Outer index space.
`define EXT_INDEX_REG    8'h2E
`define EXT_DATA_REG     8'h2F
`define PWR_CTRL_REG     8'h02

// Extended indices behind the data register.
`define XIDX_MASK0       8'h01
`define XIDX_MASK1       8'h02
`define XIDX_CTRL1       8'h03
`define XIDX_ACK_DELAY   8'h04

// Field positions.
`define PWR_VCC_BIT      4
`define CTRL1_LOCK_BIT   0
`define CTRL1_AUTOCLR_BIT 1
`define CTRL1_LED_BIT    2
`define CTRL1_PULLUP_BIT 5
`define CTRL1_DMA_HI     7
`define CTRL1_DMA_LO     6
`define CTRL1_WMASK      8'hE7

// Reset values.
`define EXT_INDEX_RST    8'h00
`define MASK_RST         8'h00
`define CTRL1_RST        8'h00
`define ACK_DELAY_RST    8'h00
`define PWR_CTRL_RST     8'h00

// DMA select codes.
`define DMA_OFF          2'h0
`define DMA_SEL_INPACK   2'h1
`define DMA_SEL_WP       2'h2
`define DMA_SEL_BVD2     2'h3

// Timing: internal clock period and core clock period in ns.
`define INT_CLK_NS       40
`define CORE_CLK_NS      10
`define ACK_BASE_CLKS    9'h006
`define DUMMY_CLKS       2

`endif

// ### verilog/pccard_ext_pkg.sv
// Purpose: Types shared by the extended control block and its bench.
// Assumes: Constants live in pccard_ext_map.svh.
// Notes:   All state of the block is one packed struct.
package pccard_ext_pkg;

	// Timeout sequencer states.
	typedef enum logic [1:0] {
		DMA_IDLE,
		DMA_TIMING,
		DMA_DUMMY,
		DMA_WAIT_RELEASE
	} dma_state_t;

	// One register access from the index/data port.
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] index;
		logic [7:0] wdata;
	} reg_req_t;

	// Signals of the dummy cycle presented to the card.
	typedef struct packed {
		logic dummy_rd;
		logic dack;
		logic tc;
	} card_dma_t;

	// Complete state of the block.
	typedef struct packed {
		logic [7:0] ext_index;
		logic [7:0] mask0;
		logic [7:0] mask1;
		logic [7:0] ctrl1;
		logic [7:0] ack_delay;
		logic [7:0] pwr_ctrl;
		logic [7:0] rdata;
		logic       cd_prev;
		logic       dack_prev;
		logic [7:0] prescale;
		logic [8:0] ticks;
		logic [7:0] dummy_cnt;
		dma_state_t dma_state;
		card_dma_t  card_dma;
		logic [7:0] data_drive_en;
		logic       force_8bit;
		logic       activity_led_n;
		logic       pullups_on;
		logic       dma_mode;
		logic       card_dreq;
	} state_t;

endpackage
